// ==== clock_control_pkg.sv ====
package clock_control_pkg;
	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_PERIOD_NS = 4;
	localparam int RESET_PULSE_NS = 64; // Width of the driven reset pulse
	localparam int RESET_PULSE_CYC = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OSC_BUS_DIV = 2;
	localparam int VCO_FREE_DIV = 4;
	// ************************************************************
	// Register indices (byte address is four times the index)
	// ************************************************************
	localparam logic [9:0] IDX_SYNTH = 10'h034;
	localparam logic [9:0] IDX_REFDIV = 10'h035;
	localparam logic [9:0] IDX_POSTDIV = 10'h036;
	localparam logic [9:0] IDX_FLAGS = 10'h037;
	localparam logic [9:0] IDX_INT_EN = 10'h038;
	localparam logic [9:0] IDX_CLKS = 10'h039;
	localparam logic [9:0] IDX_PLLMOD = 10'h03a;
	localparam logic [9:0] IDX_RTI = 10'h03b;
	localparam logic [9:0] IDX_COP = 10'h03c;
	localparam logic [9:0] IDX_TEST0 = 10'h03d;
	localparam logic [9:0] IDX_TEST1 = 10'h03e;
	localparam logic [9:0] IDX_SERVICE = 10'h03f;
	localparam logic [9:0] IDX_OSC2 = 10'h040;
	localparam logic [9:0] IDX_IRQ_STATUS = 10'h041;
	localparam logic [9:0] IDX_IRQ_CLEAR = 10'h042;
	localparam logic [9:0] IDX_IRQ_ENABLE = 10'h043;
	localparam logic [9:0] IDX_HTCTL = 10'h2f0;
	localparam logic [9:0] IDX_LVCTL = 10'h2f1;
	localparam logic [9:0] IDX_APICTL = 10'h2f2;
	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int FLG_LOCKIF = 4;
	localparam int FLG_LOCK = 3;
	localparam int FLG_OSCIF = 1;
	localparam int FLG_OSCILLATOR_OK_STATUS = 0;
	localparam int INT_LOCKIE = 4;
	localparam int INT_OSCIE = 1;
	localparam int CLKS_BUS_CLOCK_FROM_PLL_SELECT = 7;
	localparam int CLKS_COPSEL1 = 4;
	localparam int CLKS_RTISEL = 1;
	localparam int CLKS_COPSEL0 = 0;
	localparam int OSC2_OSCILLATOR_ENABLE_BIT = 7;
	localparam int OSC2_OSC_MONITOR_RESET_ENABLE = 1;
	localparam int IRQ_LOCK_CHG = 0;
	localparam int IRQ_OSC_CHG = 1;
	localparam int IRQ_FALLBACK = 2;
	localparam int IRQ_W = 3;
	// ************************************************************
	// Write masks and reset values
	// ************************************************************
	localparam logic [7:0] MASK_REFDIV = 8'hcf;
	localparam logic [7:0] MASK_POSTDIV = 8'h1f;
	localparam logic [7:0] MASK_FLAGS_W1C = 8'hf6;
	localparam logic [7:0] MASK_INT_EN = 8'h92;
	localparam logic [7:0] MASK_PLLMOD = 8'h30;
	localparam logic [7:0] MASK_COP = 8'hc7;
	localparam logic [7:0] MASK_OSC2 = 8'h82;
	localparam logic [7:0] MASK_HTCTL = 8'h2e;
	localparam logic [7:0] MASK_LVCTL = 8'h02;
	localparam logic [7:0] MASK_APICTL = 8'h9e;
	localparam logic [7:0] RESET_CLKS = 8'h80;
	localparam logic [7:0] RESET_ZERO = 8'h00;
	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [1:0] {
		SRC_PLL = 2'b00,
		SRC_OSC = 2'b01,
		SW_TO_OSC = 2'b10,
		SW_TO_PLL = 2'b11
	} clk_state_t;
	typedef struct packed {
		logic crystal_input; // One pulse per crystal input period
		logic vco; // One pulse per VCO period
		logic irc; // Internal reference generator
		logic rc; // RC oscillator
	} src_ticks_t;
	typedef struct packed {
		logic bus;
		logic pll_ref;
		logic pll_out;
		logic loop_ctrl_osc;
		logic watchdog;
		logic real_time_interrupt;
	} clk_en_t;
endpackage

// ==== tick_divider.sv ====
`timescale 1ns/1ns
module tick_divider #(
	parameter int DIV = 2
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic tick_in,
	output logic tick_out
);
	localparam int W = (DIV > 2) ? $clog2(DIV) : 1;
	localparam logic [W-1:0] LAST = W'(DIV - 1);
	// Whole state of the divider
	typedef struct packed {
		logic [W-1:0] cnt;
		logic out;
	} div_state_t;
	div_state_t s;
	div_state_t next_s;
	// ************************************************************
	// Count input pulses, emit every DIV-th
	// ************************************************************
	always_comb begin
		next_s = s;
		next_s.out = 1'b0;
		if (tick_in) begin
			if (s.cnt == LAST) begin
				next_s.cnt = '0;
				next_s.out = 1'b1;
			end else begin
				next_s.cnt = s.cnt + 1'b1;
			end
		end
	end
	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
	assign tick_out = s.out;
	// Output pulse only follows an input pulse at the wrap
	property p_out_from_tick;
		@(posedge pclk) disable iff (!presetn) tick_out |-> $past(tick_in) && (s.cnt == '0);
	endproperty
	a_out_from_tick: assert property (p_out_from_tick) else $error("divider pulse without input");
endmodule // tick_divider

// ==== reset_pin_ctrl.sv ====
`timescale 1ns/1ns
module reset_pin_ctrl
	import clock_control_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic reset_pin_in,
	input wire logic internal_req,
	output logic reset_pin_out,
	output logic reset_pin_oe_n,
	output logic ext_reset_seen
);
	localparam logic [7:0] PULSE_LAST = 8'(RESET_PULSE_CYC - 1);
	// Whole state of the pin driver
	typedef struct packed {
		logic [7:0] cnt;
		logic drive;
		logic seen;
	} pin_state_t;
	pin_state_t s;
	pin_state_t next_s;
	// ************************************************************
	// Stretch an internal request into a fixed low pulse
	// ************************************************************
	always_comb begin
		next_s = s;
		if (internal_req) begin
			next_s.drive = 1'b1;
			next_s.cnt = '0;
		end else if (s.drive) begin
			if (s.cnt == PULSE_LAST) begin
				next_s.drive = 1'b0;
			end else begin
				next_s.cnt = s.cnt + 8'h01;
			end
		end
		// Our own drive is not an outside reset
		next_s.seen = !reset_pin_in && !s.drive;
	end
	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
	assign reset_pin_out = 1'b0;
	assign reset_pin_oe_n = !s.drive;
	assign ext_reset_seen = s.seen;
	// Request drives the pin low from the next cycle
	property p_drive_on_req;
		@(posedge pclk) disable iff (!presetn) internal_req |=> !reset_pin_oe_n;
	endproperty
	a_drive_on_req: assert property (p_drive_on_req) else $error("reset pin not driven");
endmodule // reset_pin_ctrl

// ==== pll_bypass_clock_control.sv ====
// Design decision made here: the APB register port.
`timescale 1ns/1ns
module pll_bypass_clock_control
	import clock_control_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire src_ticks_t src,
	input wire logic pll_lock_in,
	input wire logic osc_ok_in,
	input wire logic reset_pin_in,
	output logic reset_pin_out,
	output logic reset_pin_oe_n,
	output logic ext_reset_seen,
	output clk_en_t clk_en,
	output logic irq
);
	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		logic [7:0] synth;
		logic [7:0] refdiv;
		logic [7:0] postdiv;
		logic [7:0] flags; // Sticky flag bits only
		logic [7:0] int_en;
		logic [7:0] clks;
		logic [7:0] pllmod;
		logic [7:0] real_time_interrupt;
		logic [7:0] watchdog_counter;
		logic [7:0] osc2;
		logic [7:0] ht;
		logic [7:0] lv;
		logic [7:0] api;
		logic [IRQ_W-1:0] irq_status;
		logic [IRQ_W-1:0] irq_enable;
		logic lock_q; // Registered lock status
		logic osc_ok_q; // Registered oscillator status
		clk_state_t mode;
		logic pready;
		logic pslverr;
		logic [7:0] prdata;
		clk_en_t en;
		logic irq;
		logic mon_req;
	} top_state_t;
	top_state_t s;
	top_state_t next_s;
	logic osc_clk; // Gated crystal input pulses
	logic osc_half; // Oscillator over two
	logic vco_quarter; // Free VCO over four
	logic pll_tick; // PLL output pulse
	logic osc_ok_now; // Oscillator status this cycle
	logic osc_loss; // Oscillator status falling
	logic [9:0] idx;
	logic wr;
	logic [7:0] wd;
	// ************************************************************
	// Dividers and reset pin
	// ************************************************************
	tick_divider #(.DIV(OSC_BUS_DIV)) u_osc_div (
		.pclk(pclk),
		.presetn(presetn),
		.tick_in(osc_clk),
		.tick_out(osc_half)
	);
	tick_divider #(.DIV(VCO_FREE_DIV)) u_vco_div (
		.pclk(pclk),
		.presetn(presetn),
		.tick_in(src.vco),
		.tick_out(vco_quarter)
	);
	reset_pin_ctrl u_reset_pin (
		.pclk(pclk),
		.presetn(presetn),
		.reset_pin_in(reset_pin_in),
		.internal_req(s.mon_req),
		.reset_pin_out(reset_pin_out),
		.reset_pin_oe_n(reset_pin_oe_n),
		.ext_reset_seen(ext_reset_seen)
	);
	// ************************************************************
	// Clock source helpers
	// ************************************************************
	// Three-way pick of a slow tick source
	function automatic logic pick_src(input logic sel1, input logic sel0, input logic osc, input src_ticks_t t);
		pick_src = sel1 ? t.rc : (sel0 ? osc : t.irc);
	endfunction
	// Crystal pulses only count while the oscillator is enabled
	assign osc_clk = src.crystal_input && s.osc2[OSC2_OSCILLATOR_ENABLE_BIT];
	// Until lock returns the PLL runs from the free VCO over four
	assign pll_tick = s.lock_q ? src.vco : vco_quarter;
	// Oscillator status needs lock as well
	assign osc_ok_now = osc_ok_in && pll_lock_in && s.osc2[OSC2_OSCILLATOR_ENABLE_BIT];
	assign osc_loss = s.osc_ok_q && !osc_ok_now;
	assign idx = paddr[11:2];
	assign wr = psel && penable && s.pready && pwrite;
	assign wd = pwdata[7:0];
	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		next_s = s;
		// Status sampling
		next_s.lock_q = pll_lock_in;
		next_s.osc_ok_q = osc_ok_now;
		// Register writes, taken at the completing edge
		if (wr) begin
			unique case (idx)
				IDX_SYNTH: next_s.synth = wd;
				IDX_REFDIV: next_s.refdiv = wd & MASK_REFDIV;
				IDX_POSTDIV: next_s.postdiv = wd & MASK_POSTDIV;
				IDX_FLAGS: next_s.flags = s.flags & ~(wd & MASK_FLAGS_W1C);
				IDX_INT_EN: next_s.int_en = wd & MASK_INT_EN;
				IDX_CLKS: next_s.clks = wd;
				IDX_PLLMOD: next_s.pllmod = wd & MASK_PLLMOD;
				IDX_RTI: next_s.real_time_interrupt = wd;
				IDX_COP: next_s.watchdog_counter = wd & MASK_COP;
				IDX_OSC2: next_s.osc2 = wd & MASK_OSC2;
				IDX_IRQ_CLEAR: next_s.irq_status = s.irq_status & ~wd[IRQ_W-1:0];
				IDX_IRQ_ENABLE: next_s.irq_enable = wd[IRQ_W-1:0];
				IDX_HTCTL: next_s.ht = wd & MASK_HTCTL;
				IDX_LVCTL: next_s.lv = wd & MASK_LVCTL;
				IDX_APICTL: next_s.api = wd & MASK_APICTL;
				default: begin
				end
			endcase
		end
		// Flag sets beat a clear in the same cycle
		if (s.lock_q != pll_lock_in) begin
			next_s.flags[FLG_LOCKIF] = 1'b1;
			next_s.irq_status[IRQ_LOCK_CHG] = 1'b1;
		end
		if (s.osc_ok_q != osc_ok_now) begin
			next_s.flags[FLG_OSCIF] = 1'b1;
			next_s.irq_status[IRQ_OSC_CHG] = 1'b1;
		end
		// Oscillator loss forces the PLL back, even over a write of zero
		if (osc_loss) begin
			next_s.clks[CLKS_BUS_CLOCK_FROM_PLL_SELECT] = 1'b1;
			if (s.mode != SRC_PLL) begin
				next_s.irq_status[IRQ_FALLBACK] = 1'b1;
			end
		end
		// Monitor reset, only when software armed it
		next_s.mon_req = osc_loss && s.osc2[OSC2_OSC_MONITOR_RESET_ENABLE] && (s.mode != SRC_PLL);
		// Bus clock source sequencing; each hand-over waits for a fresh
		// pulse of the new source so no pulse comes early
		next_s.en.bus = 1'b0;
		unique case (s.mode)
			SRC_PLL: begin
				next_s.en.bus = pll_tick;
				// Switch only once the oscillator is reported good
				if (!s.clks[CLKS_BUS_CLOCK_FROM_PLL_SELECT] && s.osc_ok_q) begin
					next_s.mode = SW_TO_OSC;
				end
			end
			SW_TO_OSC: begin
				if (s.clks[CLKS_BUS_CLOCK_FROM_PLL_SELECT]) begin
					next_s.mode = SW_TO_PLL;
				end else if (osc_half) begin
					next_s.mode = SRC_OSC;
				end
			end
			SRC_OSC: begin
				next_s.en.bus = osc_half;
				if (s.clks[CLKS_BUS_CLOCK_FROM_PLL_SELECT]) begin
					next_s.mode = SW_TO_PLL;
				end
			end
			SW_TO_PLL: begin
				if (pll_tick) begin
					next_s.mode = SRC_PLL;
				end
			end
		endcase
		// Remaining clock enables
		next_s.en.pll_ref = (s.mode == SRC_OSC) ? osc_clk : src.irc;
		next_s.en.pll_out = pll_tick;
		next_s.en.loop_ctrl_osc = osc_clk;
		next_s.en.watchdog = pick_src(s.clks[CLKS_COPSEL1], s.clks[CLKS_COPSEL0], osc_clk, src);
		next_s.en.real_time_interrupt = pick_src(s.clks[CLKS_COPSEL1], s.clks[CLKS_RTISEL], osc_clk, src);
		// Interrupt level
		next_s.irq = (|(s.irq_status & s.irq_enable))
			|| (s.flags[FLG_LOCKIF] && s.int_en[INT_LOCKIE])
			|| (s.flags[FLG_OSCIF] && s.int_en[INT_OSCIE]);
		// APB answer one cycle into the access phase
		next_s.pready = psel && penable && !s.pready;
		next_s.pslverr = 1'b0; // Error stands only with ready
		if (psel && penable && !s.pready) begin
			next_s.pslverr = 1'b0;
			unique case (idx)
				IDX_SYNTH: next_s.prdata = s.synth;
				IDX_REFDIV: next_s.prdata = s.refdiv;
				IDX_POSTDIV: next_s.prdata = s.postdiv;
				IDX_FLAGS: next_s.prdata = {s.flags[7:4], s.lock_q, s.flags[2:1], s.osc_ok_q};
				IDX_INT_EN: next_s.prdata = s.int_en;
				IDX_CLKS: next_s.prdata = s.clks;
				IDX_PLLMOD: next_s.prdata = s.pllmod;
				IDX_RTI: next_s.prdata = s.real_time_interrupt;
				IDX_COP: next_s.prdata = s.watchdog_counter;
				IDX_OSC2: next_s.prdata = s.osc2;
				IDX_IRQ_STATUS: next_s.prdata = {5'h00, s.irq_status};
				IDX_IRQ_ENABLE: next_s.prdata = {5'h00, s.irq_enable};
				IDX_HTCTL: next_s.prdata = s.ht;
				IDX_LVCTL: next_s.prdata = s.lv;
				IDX_APICTL: next_s.prdata = s.api;
				// Reserved and write-only words read zero
				IDX_TEST0, IDX_TEST1, IDX_SERVICE, IDX_IRQ_CLEAR: next_s.prdata = 8'h00;
				default: begin
					next_s.prdata = 8'h00;
					next_s.pslverr = 1'b1;
				end
			endcase
		end
	end
	// ************************************************************
	// State register
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
			s.clks <= RESET_CLKS;
			s.mode <= SRC_PLL;
		end else begin
			s <= next_s;
		end
	end
	// Outputs straight from the state register
	assign prdata = {24'h000000, s.prdata};
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign clk_en = s.en;
	assign irq = s.irq;
	// ************************************************************
	// Checks
	// ************************************************************

	// Oscillator mode bus rate
	property p_bus_half_osc;
		@(posedge pclk) disable iff (!presetn) (s.mode == SRC_OSC) |=> (s.en.bus == $past(osc_half));
	endproperty
	a_bus_half_osc: assert property (p_bus_half_osc) else $error("bus tick not oscillator half");

	// Reference source in oscillator mode
	property p_ref_from_osc;
		@(posedge pclk) disable iff (!presetn) (s.mode == SRC_OSC) |=> (s.en.pll_ref == $past(osc_clk));
	endproperty
	a_ref_from_osc: assert property (p_ref_from_osc) else $error("reference not from oscillator");

	// Watchdog on the RC source
	property p_wdog_rc;
		@(posedge pclk) disable iff (!presetn) s.clks[CLKS_COPSEL1] |=> (s.en.watchdog == $past(src.rc));
	endproperty
	a_wdog_rc: assert property (p_wdog_rc) else $error("watchdog source wrong");

	// Periodic tick on the RC source
	property p_rti_rc;
		@(posedge pclk) disable iff (!presetn) s.clks[CLKS_COPSEL1] |=> (s.en.real_time_interrupt == $past(src.rc));
	endproperty
	a_rti_rc: assert property (p_rti_rc) else $error("periodic source wrong");

	// Status cannot outlive lock
	property p_osc_drops_with_lock;
		@(posedge pclk) disable iff (!presetn) !pll_lock_in |=> !s.osc_ok_q;
	endproperty
	a_osc_drops_with_lock: assert property (p_osc_drops_with_lock) else $error("status kept without lock");

	// Loss forces the select
	property p_fallback_sets_sel;
		@(posedge pclk) disable iff (!presetn) osc_loss |=> s.clks[CLKS_BUS_CLOCK_FROM_PLL_SELECT];
	endproperty
	a_fallback_sets_sel: assert property (p_fallback_sets_sel) else $error("select not forced");

	// Loss leaves oscillator mode
	property p_fallback_leaves_osc;
		@(posedge pclk) disable iff (!presetn) (s.mode == SRC_OSC && osc_loss) |-> ##2 (s.mode == SW_TO_PLL);
	endproperty
	a_fallback_leaves_osc: assert property (p_fallback_leaves_osc) else $error("no fallback");

	// Loss outside PLL mode is flagged
	property p_fallback_flag;
		@(posedge pclk) disable iff (!presetn) (osc_loss && s.mode != SRC_PLL) |=> s.irq_status[IRQ_FALLBACK];
	endproperty
	a_fallback_flag: assert property (p_fallback_flag) else $error("fallback not flagged");

	// Armed monitor pulls the pin two cycles after loss
	property p_monitor_drives_pin;
		@(posedge pclk) disable iff (!presetn)
			(osc_loss && s.osc2[OSC2_OSC_MONITOR_RESET_ENABLE] && s.mode != SRC_PLL) |=> ##1 !reset_pin_oe_n;
	endproperty
	a_monitor_drives_pin: assert property (p_monitor_drives_pin) else $error("monitor reset not driven");

	// Unlocked PLL rate
	property p_vco_quarter;
		@(posedge pclk) disable iff (!presetn)
			(!s.lock_q && s.mode == SRC_PLL) |=> (s.en.bus == $past(vco_quarter));
	endproperty
	a_vco_quarter: assert property (p_vco_quarter) else $error("unlocked PLL rate wrong");

	// Locked PLL follows the VCO
	property p_locked_rate;
		@(posedge pclk) disable iff (!presetn) (s.lock_q && s.mode == SRC_PLL) |=> (s.en.bus == $past(src.vco));
	endproperty
	a_locked_rate: assert property (p_locked_rate) else $error("locked PLL rate wrong");

	// No switch without a good oscillator
	property p_switch_needs_ok;
		@(posedge pclk) disable iff (!presetn) (s.mode == SRC_PLL && !s.osc_ok_q) |=> (s.mode == SRC_PLL);
	endproperty
	a_switch_needs_ok: assert property (p_switch_needs_ok) else $error("switch without oscillator");

	// Quiet bus during hand-over
	property p_no_tick_in_switch;
		@(posedge pclk) disable iff (!presetn) (s.mode == SW_TO_OSC || s.mode == SW_TO_PLL) |=> !s.en.bus;
	endproperty
	a_no_tick_in_switch: assert property (p_no_tick_in_switch) else $error("pulse during hand-over");

	// Loop clock gated by enable
	property p_loop_osc_gated;
		@(posedge pclk) disable iff (!presetn) !s.osc2[OSC2_OSCILLATOR_ENABLE_BIT] |=> !s.en.loop_ctrl_osc;
	endproperty
	a_loop_osc_gated: assert property (p_loop_osc_gated) else $error("loop clock while disabled");

	// Status changes set their sticky flags
	property p_lock_flag_set;
		@(posedge pclk) disable iff (!presetn) (s.lock_q != pll_lock_in) |=> s.flags[FLG_LOCKIF];
	endproperty
	a_lock_flag_set: assert property (p_lock_flag_set) else $error("lock change not flagged");

	// Oscillator status change flag
	property p_osc_flag_set;
		@(posedge pclk) disable iff (!presetn) (s.osc_ok_q != osc_ok_now) |=> s.flags[FLG_OSCIF];
	endproperty
	a_osc_flag_set: assert property (p_osc_flag_set) else $error("oscillator change not flagged");

	// Enabled status raises the interrupt
	property p_irq_level;
		@(posedge pclk) disable iff (!presetn) (|(s.irq_status & s.irq_enable)) |=> irq;
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("interrupt not raised");

	// Ready is a single pulse
	property p_ready_pulse;
		@(posedge pclk) disable iff (!presetn) s.pready |=> !s.pready;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");

	// Error only shows with ready
	property p_err_with_ready;
		@(posedge pclk) disable iff (!presetn) s.pslverr |-> s.pready;
	endproperty
	a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");
endmodule // pll_bypass_clock_control

// ==== osc_partner_model.sv ====
`timescale 1ns/1ns
module osc_partner_model
	import clock_control_pkg::*;
#(
	parameter int CRYS_DIV = 3,
	parameter int IRC_DIV = 7,
	parameter int RC_DIV = 5
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic osc_run,
	input wire logic lock_run,
	input wire logic ext_low,
	input wire logic reset_pin_out,
	input wire logic reset_pin_oe_n,
	output src_ticks_t src,
	output logic pll_lock_in,
	output logic osc_ok_in,
	output logic reset_pin_in
);
	// ************************************************************
	// Sources
	// ************************************************************
	int c_cnt; // Crystal divider, held at zero while the crystal is stopped
	int i_cnt; // Internal reference divider
	int r_cnt; // RC oscillator divider
	// Tick generators; VCO free-runs at one tick per cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			c_cnt <= 0;
			i_cnt <= 0;
			r_cnt <= 0;
			src <= '0;
			pll_lock_in <= 1'b0;
			osc_ok_in <= 1'b0;
		end else begin
			c_cnt <= (!osc_run || c_cnt == CRYS_DIV - 1) ? 0 : c_cnt + 1;
			i_cnt <= (i_cnt == IRC_DIV - 1) ? 0 : i_cnt + 1;
			r_cnt <= (r_cnt == RC_DIV - 1) ? 0 : r_cnt + 1;
			src.crystal_input <= osc_run && c_cnt == CRYS_DIV - 1;
			src.vco <= 1'b1;
			src.irc <= i_cnt == IRC_DIV - 1;
			src.rc <= r_cnt == RC_DIV - 1;
			pll_lock_in <= lock_run;
			osc_ok_in <= osc_run;
		end
	end
	// Pin has a pull-up; low while either party pulls it
	assign reset_pin_in = !((!reset_pin_oe_n && !reset_pin_out) || ext_low);
endmodule // osc_partner_model

// ==== pll_bypass_clock_control_tb.sv ====
`timescale 1ns/1ns
module pll_bypass_clock_control_tb;
	import clock_control_pkg::*;
	// ************************************************************
	// Signals
	// ************************************************************
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, pll_lock_in, osc_ok_in, reset_pin_in, reset_pin_out, reset_pin_oe_n, ext_reset_seen, irq;
	logic osc_run = 1'b0, lock_run = 1'b0, ext_low = 1'b0; // Partner controls
	src_ticks_t src;
	clk_en_t clk_en;
	int error_cnt = 0;
	int tests_run = 0;
	logic [31:0] rd;
	logic err;
	localparam int K_RTI = 0, K_WD = 1, K_LOOP = 2, K_PLL = 3, K_REF = 4, K_BUS = 5, K_IRQ = 6, K_OEN = 7, K_EXT = 8;
	always #2 pclk = ~pclk;
	pll_bypass_clock_control DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.src(src), .pll_lock_in(pll_lock_in), .osc_ok_in(osc_ok_in), .reset_pin_in(reset_pin_in),
		.reset_pin_out(reset_pin_out), .reset_pin_oe_n(reset_pin_oe_n), .ext_reset_seen(ext_reset_seen),
		.clk_en(clk_en), .irq(irq));
	osc_partner_model partner (.pclk(pclk), .presetn(presetn), .osc_run(osc_run), .lock_run(lock_run),
		.ext_low(ext_low), .reset_pin_out(reset_pin_out), .reset_pin_oe_n(reset_pin_oe_n), .src(src),
		.pll_lock_in(pll_lock_in), .osc_ok_in(osc_ok_in), .reset_pin_in(reset_pin_in));
	// ************************************************************
	// Helpers
	// ************************************************************
	task automatic complete_run;
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Bounded wait ran out: counted, then the run is closed
	task automatic give_up(input int k);
		error_cnt++;
		$display("unexpected at %0t: wait on %h got %h", $time, k, 0);
		complete_run();
	endtask
	function automatic logic probe(input int k);
		case (k)
			K_IRQ: return irq;
			K_OEN: return reset_pin_oe_n;
			K_EXT: return ext_reset_seen;
			default: return clk_en[k];
		endcase
	endfunction
	// APB transfer; request held until pready is sampled high
	task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h0, wd};
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i == 20) give_up(99);
	endtask
	task automatic rdchk(input logic [9:0] idx, input logic [7:0] mask, input logic [7:0] exp);
		apb(1'b0, idx, 8'h00);
		chk(rd & {24'h0, mask}, {24'h0, exp});
		chk({31'h0, err}, 32'h0);
	endtask
	task automatic wait_for(input int k, input logic v, input int bound);
		for (int i = 0; i < bound; i++) begin
			@(posedge pclk);
			if (probe(k) === v) return;
		end
		give_up(k);
	endtask
	// Spacing between the 2nd and 3rd pulse, skipping switch transients
	task automatic gap(input int k, input int exp);
		int n;
		wait_for(k, 1'b1, 60);
		wait_for(k, 1'b1, 60);
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (probe(k) !== 1'b1 && n < 60);
		chk(n, exp);
	endtask
	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic regs_after_reset;
		logic [9:0] idx [9] = '{IDX_SYNTH, IDX_REFDIV, IDX_POSTDIV, IDX_PLLMOD, IDX_RTI, IDX_COP, IDX_HTCTL,
			IDX_LVCTL, IDX_APICTL};
		logic [7:0] msk [9] = '{8'hff, MASK_REFDIV, MASK_POSTDIV, MASK_PLLMOD, 8'hff, MASK_COP, MASK_HTCTL,
			MASK_LVCTL, MASK_APICTL};
		rdchk(IDX_CLKS, 8'hff, RESET_CLKS);
		rdchk(IDX_FLAGS, 8'hff, 8'h00);
		rdchk(IDX_IRQ_STATUS, 8'hff, 8'h00);
		rdchk(IDX_TEST0, 8'hff, 8'h00);
		apb(1'b1, IDX_SERVICE, 8'hff);
		rdchk(IDX_SERVICE, 8'hff, 8'h00);
		apb(1'b0, 10'h050, 8'h00);
		chk({31'h0, err}, 32'h1);
		for (int i = 0; i < 9; i++) begin
			rdchk(idx[i], 8'hff, 8'h00);
			apb(1'b1, idx[i], 8'hff);
			rdchk(idx[i], 8'hff, msk[i]);
			apb(1'b1, idx[i], 8'h00);
		end
	endtask
	task automatic enter_external;
		apb(1'b1, IDX_OSC2, 8'h82);
		osc_run <= 1'b1;
		lock_run <= 1'b1;
		for (int i = 0; i < 20; i++) begin
			apb(1'b0, IDX_FLAGS, 8'h00);
			if ((rd & 32'h9) === 32'h9) break;
		end
		chk(rd & 32'h9, 32'h9);
		gap(K_BUS, 1);
		apb(1'b1, IDX_FLAGS, 8'h12);
		rdchk(IDX_FLAGS, 8'hff, 8'h09);
		apb(1'b1, IDX_INT_EN, 8'h12);
		rdchk(IDX_INT_EN, 8'hff, 8'h12);
		apb(1'b1, IDX_CLKS, 8'h00);
		repeat (12) @(posedge pclk); // Hand-over settles
		gap(K_BUS, OSC_BUS_DIV * 3);
		gap(K_REF, 3);
		gap(K_LOOP, 3);
		chk({31'h0, irq}, 32'h0);
	endtask
	task automatic lose_lock;
		int n;
		lock_run <= 1'b0;
		wait_for(K_OEN, 1'b0, 10);
		n = 1;
		while (reset_pin_oe_n === 1'b0 && n < 40) begin
			@(posedge pclk);
			n++;
		end
		chk(n - 1, RESET_PULSE_CYC);
		rdchk(IDX_CLKS, 8'h80, 8'h80);
		rdchk(IDX_FLAGS, 8'hff, 8'h12);
		rdchk(IDX_IRQ_STATUS, 8'h04, 8'h04);
		gap(K_PLL, VCO_FREE_DIV);
		gap(K_BUS, VCO_FREE_DIV);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, IDX_INT_EN, 8'h00);
		apb(1'b1, IDX_IRQ_ENABLE, 8'h04);
		wait_for(K_IRQ, 1'b1, 5);
		apb(1'b1, IDX_IRQ_ENABLE, 8'h00);
		wait_for(K_IRQ, 1'b0, 5);
		apb(1'b1, IDX_IRQ_ENABLE, 8'h04);
		lock_run <= 1'b1;
		repeat (10) @(posedge pclk);
		apb(1'b1, IDX_IRQ_CLEAR, 8'h07);
		rdchk(IDX_IRQ_STATUS, 8'hff, 8'h00);
		apb(1'b1, IDX_FLAGS, 8'h12);
		rdchk(IDX_FLAGS, 8'hff, 8'h09);
		apb(1'b1, IDX_INT_EN, 8'h12);
		repeat (3) @(posedge pclk);
		chk({31'h0, irq}, 32'h0);
	endtask
	task automatic tick_sources;
		logic [7:0] sel [4] = '{8'h80, 8'h81, 8'h82, 8'h90};
		int wd [4] = '{7, 3, 7, 5};
		int rt [4] = '{7, 7, 3, 5};
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, IDX_CLKS, sel[i]);
			gap(K_WD, wd[i]);
			gap(K_RTI, rt[i]);
		end
	endtask
	task automatic external_reset;
		ext_low <= 1'b1;
		wait_for(K_EXT, 1'b1, 5);
		ext_low <= 1'b0;
		wait_for(K_EXT, 1'b0, 5);
		chk({31'h0, reset_pin_oe_n}, 32'h1);
	endtask
	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		regs_after_reset();
		enter_external();
		lose_lock();
		tick_sources();
		external_reset();
		complete_run();
	end
endmodule // pll_bypass_clock_control_tb
